// [core/sfrsd_core.sv]
// Serial flash command front end: software reset, status register one copies and parameter dword sixteen.
// Assumes the serial pins are synchronous to CLOCK and each serial clock phase lasts at least three CLOCK cycles.
`timescale 1ns/10ps
`include "sfrsd_params.svh"

module sfrsd_core #(
    parameter logic [15:0] NV_WRITE_CYCLES = `SFRSD_NV_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Serial bus
    input wire logic SPI_CS_N,
    input wire logic SPI_SCK,
    input wire logic [3:0] SPI_IO_IN,
    output logic [3:0] SPI_IO_OUT,
    output logic [3:0] SPI_IO_OE,
    // Interface mode of the device
    input wire sfrsd_pkg::sfrsd_lane_t IO_MODE,
    // Status towards the rest of the device
    output logic [7:0] SR1_EFFECTIVE,
    output logic [7:0] SR1_NV,
    output logic SR1_BUSY,
    output logic SR1_WEL,
    output logic SOFT_RESET
);

    logic sck_d_ff;
    logic sck_rise;
    logic sck_fall;
    logic byte_valid;
    logic [7:0] byte_data;
    sfrsd_pkg::sfrsd_state_t state_ff;
    sfrsd_pkg::sfrsd_state_t nxt_state;
    logic [7:0] cmd_ff;
    logic [7:0] nxt_cmd;
    logic [7:0] prev_cmd_ff;
    logic [7:0] nxt_prev_cmd;
    logic [23:0] addr_ff;
    logic [23:0] nxt_addr;
    logic [1:0] addr_cnt_ff;
    logic [1:0] nxt_addr_cnt;
    logic [7:0] tx_ff;
    logic [7:0] nxt_tx;
    logic [3:0] tx_cnt_ff;
    logic [3:0] nxt_tx_cnt;
    logic [3:0] io_out_ff;
    logic [3:0] nxt_io_out;
    logic [3:0] io_oe_ff;
    logic [3:0] nxt_io_oe;
    logic [7:0] nv_ff;
    logic [7:0] nxt_nv;
    logic [7:0] vol_ff;
    logic [7:0] nxt_vol;
    logic vol_act_ff;
    logic nxt_vol_act;
    logic wr_vol_ff;
    logic nxt_wr_vol;
    logic wel_ff;
    logic nxt_wel;
    logic busy_ff;
    logic nxt_busy;
    logic [15:0] busy_cnt_ff;
    logic [15:0] nxt_busy_cnt;
    logic [7:0] pend_ff;
    logic [7:0] nxt_pend;
    logic loaded_ff;
    logic nxt_loaded;
    logic soft_rst_ff;
    logic nxt_soft_rst;

    // Edge detection on the sampled serial clock; the pin is already synchronous.
    assign sck_rise = SPI_SCK & ~sck_d_ff;
    assign sck_fall = ~SPI_SCK & sck_d_ff;

    sfrsd_lane_shift u_shift (
        .clk(CLOCK),
        .nrst(NRST),
        .cs_n(SPI_CS_N),
        .sck_rise(sck_rise),
        .io_in(SPI_IO_IN),
        .lanes(IO_MODE),
        .byte_valid(byte_valid),
        .byte_data(byte_data)
    );

    always_comb
    begin
        logic [31:0] dw16;
        logic [7:0] status;
        logic [7:0] sfdp;
        logic [3:0] step;
        logic load;
        logic [7:0] load_val;
        dw16 = `SFRSD_DW16;
        status = {vol_ff[7:2], wel_ff, busy_ff};
        sfdp = `SFRSD_SFDP_FILL;
        if (addr_ff[23:2] == `SFRSD_DW16_ADDR >> 2)
        begin
            sfdp = dw16[{addr_ff[1:0], 3'h0} +: 8];
        end
        step = (IO_MODE == sfrsd_pkg::LANE_X1) ? 4'h1 : (IO_MODE == sfrsd_pkg::LANE_X2) ? 4'h2 : 4'h4;
        load = 1'b0;
        load_val = status;
        nxt_state = state_ff;
        nxt_cmd = cmd_ff;
        nxt_prev_cmd = prev_cmd_ff;
        nxt_addr = addr_ff;
        nxt_addr_cnt = addr_cnt_ff;
        nxt_tx = tx_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_nv = nv_ff;
        nxt_vol = vol_ff;
        nxt_vol_act = vol_act_ff;
        nxt_wr_vol = wr_vol_ff;
        nxt_wel = wel_ff;
        nxt_busy = busy_ff;
        nxt_busy_cnt = busy_cnt_ff;
        nxt_pend = pend_ff;
        nxt_loaded = 1'b1;
        nxt_soft_rst = 1'b0;
        // The working copy is filled one cycle after reset release, as a reset may only load constants.
        if (!loaded_ff)
        begin
            nxt_vol = nv_ff;
        end
        // Completion of the non-volatile write: the working copy follows unless the volatile copy rules.
        if (busy_cnt_ff != 16'h0000)
        begin
            nxt_busy_cnt = busy_cnt_ff - 16'h0001;
            if (busy_cnt_ff == 16'h0001)
            begin
                nxt_busy = 1'b0;
                nxt_wel = 1'b0;
                nxt_nv = pend_ff;
                if (!vol_act_ff)
                begin
                    nxt_vol = pend_ff;
                end
            end
        end
        if (SPI_CS_N)
        begin
            nxt_state = sfrsd_pkg::ST_OPCODE;
        end
        else if (byte_valid)
        begin
            unique case (state_ff)
                sfrsd_pkg::ST_OPCODE:
                begin
                    nxt_cmd = byte_data;
                    nxt_prev_cmd = byte_data;
                    nxt_state = sfrsd_pkg::ST_IGNORE;
                    if (byte_data == `SFRSD_OP_RST)
                    begin
                        if (prev_cmd_ff == `SFRSD_OP_RST_EN)
                        begin
                            // Reset reloads the working copy and aborts a pending write.
                            nxt_soft_rst = 1'b1;
                            nxt_vol = nv_ff;
                            nxt_vol_act = 1'b0;
                            nxt_wel = 1'b0;
                            nxt_busy = 1'b0;
                            nxt_busy_cnt = 16'h0000;
                            // An abort in the write's last cycle must not let the stored copy move past the working one.
                            nxt_nv = nv_ff;
                        end
                    end
                    else if (byte_data == `SFRSD_OP_RDSR)
                    begin
                        load = 1'b1;
                        nxt_state = sfrsd_pkg::ST_OUT;
                    end
                    else if (busy_ff)
                    begin
                        nxt_state = sfrsd_pkg::ST_IGNORE;
                    end
                    else if (byte_data == `SFRSD_OP_WREN)
                    begin
                        nxt_wel = 1'b1;
                    end
                    else if (byte_data == `SFRSD_OP_WRSR)
                    begin
                        if (prev_cmd_ff == `SFRSD_OP_VWREN || wel_ff)
                        begin
                            nxt_wr_vol = (prev_cmd_ff == `SFRSD_OP_VWREN);
                            nxt_state = sfrsd_pkg::ST_WDATA;
                        end
                    end
                    else if (byte_data == `SFRSD_OP_RDSFDP)
                    begin
                        nxt_addr_cnt = 2'h0;
                        nxt_state = sfrsd_pkg::ST_ADDR;
                    end
                end
                sfrsd_pkg::ST_WDATA:
                begin
                    nxt_state = sfrsd_pkg::ST_IGNORE;
                    if (wr_vol_ff)
                    begin
                        nxt_vol = (byte_data & `SFRSD_SR1_WR_MASK) | (vol_ff & ~`SFRSD_SR1_WR_MASK);
                        nxt_vol_act = 1'b1;
                    end
                    else
                    begin
                        nxt_pend = (byte_data & `SFRSD_SR1_WR_MASK) | (nv_ff & ~`SFRSD_SR1_WR_MASK);
                        nxt_busy = 1'b1;
                        nxt_busy_cnt = NV_WRITE_CYCLES;
                    end
                end
                sfrsd_pkg::ST_ADDR:
                begin
                    nxt_addr = {addr_ff[15:0], byte_data};
                    nxt_addr_cnt = addr_cnt_ff + 2'h1;
                    if (addr_cnt_ff == `SFRSD_ADDR_BYTES - 2'h1)
                    begin
                        nxt_state = sfrsd_pkg::ST_DUMMY;
                    end
                end
                sfrsd_pkg::ST_DUMMY:
                begin
                    load = 1'b1;
                    load_val = sfdp;
                    nxt_addr = addr_ff + 24'h000001;
                    nxt_state = sfrsd_pkg::ST_OUT;
                end
                default:
                begin
                    nxt_state = state_ff;
                end
            endcase
        end
        else if (state_ff == sfrsd_pkg::ST_OUT && sck_fall)
        begin
            nxt_tx = tx_ff << step;
            nxt_tx_cnt = tx_cnt_ff - step;
            if (tx_cnt_ff == step)
            begin
                load = 1'b1;
                load_val = (cmd_ff == `SFRSD_OP_RDSR) ? status : sfdp;
                if (cmd_ff != `SFRSD_OP_RDSR)
                begin
                    nxt_addr = addr_ff + 24'h000001;
                end
            end
        end
        if (load)
        begin
            nxt_tx = load_val;
            nxt_tx_cnt = 4'h8;
        end
        // Output lanes follow the interface mode; single lane answers on line one.
        nxt_io_out = 4'h0;
        nxt_io_oe = 4'h0;
        if (!SPI_CS_N && nxt_state == sfrsd_pkg::ST_OUT)
        begin
            unique case (IO_MODE)
                sfrsd_pkg::LANE_X1:
                begin
                    nxt_io_out = {2'h0, nxt_tx[7], 1'h0};
                    nxt_io_oe = 4'h2;
                end
                sfrsd_pkg::LANE_X2:
                begin
                    nxt_io_out = {2'h0, nxt_tx[7:6]};
                    nxt_io_oe = 4'h3;
                end
                default:
                begin
                    nxt_io_out = nxt_tx[7:4];
                    nxt_io_oe = 4'hf;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            sck_d_ff <= 1'b0;
            state_ff <= sfrsd_pkg::ST_OPCODE;
            cmd_ff <= 8'h00;
            prev_cmd_ff <= 8'h00;
            addr_ff <= 24'h000000;
            addr_cnt_ff <= 2'h0;
            tx_ff <= 8'h00;
            tx_cnt_ff <= 4'h0;
            io_out_ff <= 4'h0;
            io_oe_ff <= 4'h0;
            nv_ff <= `SFRSD_SR1_RST;
            vol_ff <= `SFRSD_SR1_RST;
            vol_act_ff <= 1'b0;
            wr_vol_ff <= 1'b0;
            wel_ff <= 1'b0;
            busy_ff <= 1'b0;
            busy_cnt_ff <= 16'h0000;
            pend_ff <= `SFRSD_SR1_RST;
            loaded_ff <= 1'b0;
            soft_rst_ff <= 1'b0;
        end
        else
        begin
            sck_d_ff <= SPI_SCK;
            state_ff <= nxt_state;
            cmd_ff <= nxt_cmd;
            prev_cmd_ff <= nxt_prev_cmd;
            addr_ff <= nxt_addr;
            addr_cnt_ff <= nxt_addr_cnt;
            tx_ff <= nxt_tx;
            tx_cnt_ff <= nxt_tx_cnt;
            io_out_ff <= nxt_io_out;
            io_oe_ff <= nxt_io_oe;
            nv_ff <= nxt_nv;
            vol_ff <= nxt_vol;
            vol_act_ff <= nxt_vol_act;
            wr_vol_ff <= nxt_wr_vol;
            wel_ff <= nxt_wel;
            busy_ff <= nxt_busy;
            busy_cnt_ff <= nxt_busy_cnt;
            pend_ff <= nxt_pend;
            loaded_ff <= nxt_loaded;
            soft_rst_ff <= nxt_soft_rst;
        end
    end

    assign SPI_IO_OUT = io_out_ff;
    assign SPI_IO_OE = io_oe_ff;
    assign SR1_EFFECTIVE = vol_ff;
    assign SR1_NV = nv_ff;
    assign SR1_BUSY = busy_ff;
    assign SR1_WEL = wel_ff;
    assign SOFT_RESET = soft_rst_ff;

endmodule // sfrsd_core

// [core/sfrsd_lane_shift.sv]
// Byte assembler for the serial data lines in one, two or four lane mode.
// Assumes the caller gives a one-cycle pulse for each rising serial clock edge.
`timescale 1ns/10ps

module sfrsd_lane_shift (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Serial side
    input wire logic cs_n,
    input wire logic sck_rise,
    input wire logic [3:0] io_in,
    input wire sfrsd_pkg::sfrsd_lane_t lanes,
    // Assembled byte
    output logic byte_valid,
    output logic [7:0] byte_data
);

    logic [7:0] sh_ff;
    logic [7:0] nxt_sh;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic valid_ff;
    logic nxt_valid;

    always_comb
    begin
        logic [7:0] shifted;
        logic [3:0] step;
        shifted = sh_ff;
        step = 4'h1;
        unique case (lanes)
            sfrsd_pkg::LANE_X1:
            begin
                shifted = {sh_ff[6:0], io_in[0]};
                step = 4'h1;
            end
            sfrsd_pkg::LANE_X2:
            begin
                shifted = {sh_ff[5:0], io_in[1:0]};
                step = 4'h2;
            end
            default:
            begin
                shifted = {sh_ff[3:0], io_in[3:0]};
                step = 4'h4;
            end
        endcase
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_valid = 1'b0;
        if (cs_n)
        begin
            nxt_cnt = 4'h0;
        end
        else if (sck_rise)
        begin
            nxt_sh = shifted;
            if (cnt_ff + step == 4'h8)
            begin
                nxt_cnt = 4'h0;
                nxt_valid = 1'b1;
            end
            else
            begin
                nxt_cnt = cnt_ff + step;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sh_ff <= 8'h00;
            cnt_ff <= 4'h0;
            valid_ff <= 1'b0;
        end
        else
        begin
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            valid_ff <= nxt_valid;
        end
    end

    assign byte_valid = valid_ff;
    assign byte_data = sh_ff;

endmodule // sfrsd_lane_shift

// [core/sfrsd_params.svh]
// Constants for the serial flash reset and status discovery front end.
// Assumes it is included by bare name from the core files only.
`ifndef SFRSD_PARAMS_SVH
`define SFRSD_PARAMS_SVH

// Instruction codes seen on the data lines.
`define SFRSD_OP_RST_EN 8'h66
`define SFRSD_OP_RST 8'h99
`define SFRSD_OP_WREN 8'h06
`define SFRSD_OP_VWREN 8'h50
`define SFRSD_OP_WRSR 8'h01
`define SFRSD_OP_RDSR 8'h05
`define SFRSD_OP_RDSFDP 8'h5a

// Fields of the sixteenth basic parameter dword, high field first.
`define SFRSD_DW16_ENTER4B 8'h80
`define SFRSD_DW16_EXIT4B 10'h300
`define SFRSD_DW16_SOFTRST 6'h10
`define SFRSD_DW16_RFU 1'h1
`define SFRSD_DW16_SR1CFG 7'h68
`define SFRSD_DW16 {`SFRSD_DW16_ENTER4B, `SFRSD_DW16_EXIT4B, `SFRSD_DW16_SOFTRST, `SFRSD_DW16_RFU, \
    `SFRSD_DW16_SR1CFG}
`define SFRSD_DW16_ADDR 24'h00003c
`define SFRSD_SFDP_FILL 8'hff

// Status register one: reset value, the bits that a status write may change and the stored write time.
`define SFRSD_SR1_RST 8'h00
`define SFRSD_SR1_WR_MASK 8'hfc
`define SFRSD_NV_WRITE_CYCLES 16'h0008

// Address phase length in bytes for discoverable-parameter reads.
`define SFRSD_ADDR_BYTES 2'h3

`endif

// [core/sfrsd_pkg.sv]
// Types shared by the serial flash reset and status discovery front end.
// Assumes nothing of its surroundings.
package sfrsd_pkg;

    typedef enum logic [1:0] {LANE_X1, LANE_X2, LANE_X4} sfrsd_lane_t;

    typedef enum logic [2:0] {ST_OPCODE, ST_WDATA, ST_ADDR, ST_DUMMY, ST_OUT, ST_IGNORE} sfrsd_state_t;

endpackage

// [dv/sfrsd_core_test.sv]
// Self-checking bench for sfrsd_core driven through the host model.
// Assumes the checker is bound to every sfrsd_core instance below.
`timescale 1ns/10ps

module sfrsd_core_test;
    localparam logic [15:0] NVW = 16'h00c8;
    logic clock = 1'b0;
    logic nrst;
    logic cs_n;
    logic sck;
    logic [3:0] io_in;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    sfrsd_pkg::sfrsd_lane_t mode;
    logic [7:0] sr1_eff;
    logic [7:0] sr1_nv;
    logic busy;
    logic wel;
    logic soft_rst;
    logic [31:0] rx;
    logic [7:0] d;
    logic [7:0] v;
    logic [23:0] a;
    int fail_count = 0;
    int total_checks = 0;
    int rst_seen = 0;

    always #20 clock = ~clock;

    sfrsd_core #(.NV_WRITE_CYCLES(NVW)) dut (.CLOCK(clock), .NRST(nrst), .SPI_CS_N(cs_n), .SPI_SCK(sck),
        .SPI_IO_IN(io_in), .SPI_IO_OUT(io_out), .SPI_IO_OE(io_oe), .IO_MODE(mode), .SR1_EFFECTIVE(sr1_eff),
        .SR1_NV(sr1_nv), .SR1_BUSY(busy), .SR1_WEL(wel), .SOFT_RESET(soft_rst));
    sfrsd_host host (.clk(clock), .cs_n(cs_n), .sck(sck), .io(io_in), .io_out(io_out), .mode(mode));

    always @(posedge clock)
        if (soft_rst === 1'b1)
            rst_seen <= rst_seen + 1;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [7:0] exp_sfdp(input logic [23:0] adr);
        logic [31:0] dw;
        dw = {8'h80, 10'h300, 6'h10, 1'b1, 7'h68};
        return (adr >= 24'h3c && adr <= 24'h3f) ? dw[8 * (adr - 24'h3c) +: 8] : 8'hff;
    endfunction

    task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int n);
        host.frame({op, dat, 48'h0}, n, 0, rx);
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(posedge clock);
        if (busy !== 1'b0)
        begin
            $display("CHECK FAILED busy expected 0 seen %b", busy);
            fail_count++;
            end_of_test();
        end
    endtask

    task automatic set_mode(input int m);
        @(posedge clock);
        mode <= sfrsd_pkg::sfrsd_lane_t'(m);
        @(posedge clock);
    endtask

    initial
    begin
        nrst = 1'b0;
        mode = sfrsd_pkg::LANE_X1;
        void'($urandom(4800));
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        chk("sr1_nv", 32'h0, {24'h0, sr1_nv});
        chk("sr1_eff", 32'h0, {24'h0, sr1_eff});
        $display("test power-up done");
        // The first read starts on the dword itself, the others at random places around it.
        for (int m = 0; m < 3; m++)
        begin
            set_mode(m);
            a = (m == 0) ? 24'h3c : 24'h38 + 24'($urandom_range(8));
            host.frame({8'h5a, a, 8'h00, 24'h0}, 5, 4, rx);
            chk("sfdp", {exp_sfdp(a), exp_sfdp(a + 1), exp_sfdp(a + 2), exp_sfdp(a + 3)}, rx);
        end
        $display("test parameter read done");
        d = 8'($urandom());
        cmd(8'h01, d, 2);
        repeat (4) @(posedge clock);
        chk("nv_locked", 32'h0, {24'h0, sr1_nv});
        cmd(8'h06, 8'h00, 1);
        chk("wel", 32'h1, {31'h0, wel});
        cmd(8'h01, d, 2);
        host.frame({8'h05, 56'h0}, 1, 1, rx);
        chk("status_busy", 32'h3, rx);
        wait_idle();
        chk("nv_write", {24'h0, d & 8'hfc}, {24'h0, sr1_nv});
        chk("eff_follow", {24'h0, d & 8'hfc}, {24'h0, sr1_eff});
        $display("test stored write done");
        v = 8'($urandom()) ^ d;
        cmd(8'h50, 8'h00, 1);
        cmd(8'h01, v, 2);
        chk("vol_eff", {24'h0, v & 8'hfc}, {24'h0, sr1_eff});
        chk("vol_nv", {24'h0, d & 8'hfc}, {24'h0, sr1_nv});
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, ~v, 2);
        wait_idle();
        chk("vol_keep", {24'h0, v & 8'hfc}, {24'h0, sr1_eff});
        $display("test volatile copy done");
        cmd(8'h99, 8'h00, 1);
        cmd(8'h66, 8'h00, 1);
        cmd(8'h05, 8'h00, 1);
        cmd(8'h99, 8'h00, 1);
        chk("no_reset", 32'h0, 32'(rst_seen));
        for (int m = 2; m >= 0; m--)
        begin
            set_mode(m);
            cmd(8'h66, 8'h00, 1);
            cmd(8'h99, 8'h00, 1);
            chk("resets", 32'(3 - m), 32'(rst_seen));
            chk("eff_reload", {24'h0, ~v & 8'hfc}, {24'h0, sr1_eff});
        end
        $display("test soft reset done");
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        chk("reset_nv", 32'h0, {24'h0, sr1_nv});
        chk("reset_eff", 32'h0, {24'h0, sr1_eff});
        $display("test second reset done");
        end_of_test();
    end
endmodule // sfrsd_core_test

bind sfrsd_core sfrsd_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_props (.CLOCK(CLOCK), .NRST(NRST),
    .SPI_CS_N(SPI_CS_N), .SPI_SCK(SPI_SCK), .SPI_IO_IN(SPI_IO_IN), .SPI_IO_OUT(SPI_IO_OUT), .SPI_IO_OE(SPI_IO_OE),
    .IO_MODE(IO_MODE), .SR1_EFFECTIVE(SR1_EFFECTIVE), .SR1_NV(SR1_NV), .SR1_BUSY(SR1_BUSY), .SR1_WEL(SR1_WEL),
    .SOFT_RESET(SOFT_RESET));

// [dv/sfrsd_host.sv]
// Host controller model that frames commands on the serial lines, mode 0.
// Assumes one caller at a time and a free-running clk; serial clock idles low outside frames.
`timescale 1ns/10ps

module sfrsd_host (
    // Clock
    input wire logic clk,
    // Serial lines towards the device
    output logic cs_n,
    output logic sck,
    output logic [3:0] io,
    input wire logic [3:0] io_out,
    // Lane width in use
    input wire sfrsd_pkg::sfrsd_lane_t mode
);
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        io = 4'h0;
    end

    // Sends ntx bytes from the top of tx, then clocks in nrx bytes; each serial phase lasts three cycles or more.
    task automatic frame(input logic [63:0] tx, input int ntx, input int nrx, output logic [31:0] rx);
        int w;
        int n;
        w = (mode == sfrsd_pkg::LANE_X4) ? 4 : (mode == sfrsd_pkg::LANE_X2) ? 2 : 1;
        n = ntx * 8 / w;
        rx = 32'h0;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < n + nrx * 8 / w; i++)
        begin
            @(posedge clk);
            if (i >= n)
                rx = (rx << w) | ((w == 1) ? {31'h0, io_out[1]} : {28'h0, io_out & ((w == 2) ? 4'h3 : 4'hf)});
            sck <= 1'b0;
            // Released lines toggle so that a stale value is never mistaken for an answer.
            if (i < n)
                io <= tx[63 -: 4] >> (4 - w);
            else
                io <= ~io;
            if (i < n)
                tx = tx << w;
            repeat (3) @(posedge clk);
            sck <= 1'b1;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        sck <= 1'b0;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        io <= ~io;
        repeat (3) @(posedge clk);
    endtask
endmodule // sfrsd_host

// [dv/sfrsd_props.sv]
// Concurrent checks on the ports of the reset and status front end.
// Assumes it is bound to sfrsd_core with the same write-time parameter.
`timescale 1ns/10ps

module sfrsd_props #(
    parameter logic [15:0] NV_WRITE_CYCLES = 16'h0008
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Serial bus
    input wire logic SPI_CS_N,
    input wire logic SPI_SCK,
    input wire logic [3:0] SPI_IO_IN,
    input wire logic [3:0] SPI_IO_OUT,
    input wire logic [3:0] SPI_IO_OE,
    // Mode and status
    input wire sfrsd_pkg::sfrsd_lane_t IO_MODE,
    input wire logic [7:0] SR1_EFFECTIVE,
    input wire logic [7:0] SR1_NV,
    input wire logic SR1_BUSY,
    input wire logic SR1_WEL,
    input wire logic SOFT_RESET
);
    localparam int NVB = int'(NV_WRITE_CYCLES) + 2;
    logic [1:0] up_cnt_ff;

    always_ff @(posedge CLOCK or negedge NRST)
        if (!NRST)
            up_cnt_ff <= 2'h0;
        else if (up_cnt_ff != 2'h3)
            up_cnt_ff <= up_cnt_ff + 2'h1;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    property p_rst_state; SOFT_RESET |-> SR1_EFFECTIVE == SR1_NV && !SR1_WEL && !SR1_BUSY; endproperty
    a_rst_state: assert property (p_rst_state) else $error("soft reset left status wrong");
    property p_rst_time; SOFT_RESET |-> !SPI_CS_N && $past(SPI_SCK, 2); endproperty
    a_rst_time: assert property (p_rst_time) else $error("soft reset outside a byte end");
    property p_oe_off; SPI_CS_N ##1 SPI_CS_N |-> SPI_IO_OE == 4'h0; endproperty
    a_oe_off: assert property (p_oe_off) else $error("lines driven while deselected");
    property p_oe_width;
        SPI_IO_OE != 4'h0 |->
            SPI_IO_OE == ((IO_MODE == sfrsd_pkg::LANE_X4) ? 4'hf : (IO_MODE == sfrsd_pkg::LANE_X2) ? 4'h3 : 4'h2);
    endproperty
    a_oe_width: assert property (p_oe_width) else $error("driven lanes do not match mode");
    property p_power_up; up_cnt_ff == 2'h1 |-> SR1_EFFECTIVE == SR1_NV; endproperty
    a_power_up: assert property (p_power_up) else $error("working copy differs after power-up");
    property p_busy_wel; $rose(SR1_BUSY) |-> $past(SR1_WEL); endproperty
    a_busy_wel: assert property (p_busy_wel) else $error("write started without enable");
    property p_busy_len; $rose(SR1_BUSY) |-> ##[1:NVB] !SR1_BUSY; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy lasts too long");
    property p_nv_busy; $changed(SR1_NV) |-> $past(SR1_BUSY) && !SR1_BUSY; endproperty
    a_nv_busy: assert property (p_nv_busy) else $error("stored copy changed outside a write");
    property p_low_bits; SR1_NV[1:0] == 2'h0 && SR1_EFFECTIVE[1:0] == 2'h0; endproperty
    a_low_bits: assert property (p_low_bits) else $error("read-only status bits stored");
    property p_wel_set; $rose(SR1_WEL) |-> !SPI_CS_N && $past(SPI_SCK, 2); endproperty
    a_wel_set: assert property (p_wel_set) else $error("enable latch set outside a byte end");

    c_reset: cover property (SOFT_RESET);
    c_write: cover property ($fell(SR1_BUSY));
    c_quad: cover property (SPI_IO_OE == 4'hf);
endmodule // sfrsd_props
